// ==== twc_bench.sv ====
// Purpose: Self-checking bench for the three-wire control port host
// Assumes: Device model on the far side; fixed seed
// Notes: Item reads expect 5A plus the count of earlier item reads
`timescale 1ns/1ps
module twc_bench
   import twc_pkg::*;
;
   logic clock, rst, cmd_valid, cmd_ready, rsp_valid, dev_reset, bclk, sel;
   logic h_o, h_oe, d_o, d_oe;
   logic [1:0] slow;
   logic [7:0] ctrl_q, wbyte_q, addr_q, d, s1;
   twc_cmd_type cmd;
   twc_rsp_type rsp, r;
   int nbytes, perr, fails, n_compared, nread, clash, nb;
   wire line = h_oe ? h_o : d_o;

   twc_host dut_u (.clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp), .dev_reset(dev_reset),
      .ctl_bit_clock(bclk), .addr_data_select(sel), .ctl_serial_data_i(line),
      .ctl_serial_data_o(h_o), .ctl_serial_data_oe(h_oe));
   twc_dev_model dev_u (.dev_reset(dev_reset), .ctl_bit_clock(bclk),
      .addr_data_select(sel), .line(line), .slow(slow), .data_o(d_o), .data_oe(d_oe),
      .ctrl_q(ctrl_q), .wbyte_q(wbyte_q), .addr_q(addr_q), .nbytes(nbytes), .perr(perr));

   // ==========
   // Helpers
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(negedge clock) begin
      if (h_oe === 1'b1 && d_oe === 1'b1)
         clash++;
   end
   function automatic logic [7:0] item_val(int n);
      return 8'h5A + n[7:0];
   endfunction
   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic run(twc_kind_type k, logic [7:0] v);
      int i;
      i = 0;
      while (cmd_ready !== 1'b1 && i < 5000) begin
         @(negedge clock);
         i++;
      end
      if (i == 5000)
         check("ready wait", 8'h00, 8'h01);
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd <= '{kind: k, data: v};
      @(posedge clock);
      cmd_valid <= 1'b0;
      i = 0;
      // Reset gives no answer; let cmd_ready fall before the next request
      if (k == TWC_CMD_RESET)
         repeat (4) @(negedge clock);
      while (k != TWC_CMD_RESET && rsp_valid !== 1'b1 && i < 20000) begin
         @(negedge clock);
         i++;
      end
      if (i == 20000)
         check("response wait", 8'h00, 8'h01);
      r = rsp;
   endtask

   // ==========
   // Scenarios
   initial begin
      rst = 1'b1;
      cmd_valid = 1'b0;
      cmd = '0;
      slow = 2'h0;
      fails = 0;
      n_compared = 0;
      nread = 0;
      clash = 0;
      nb = $urandom(69);
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      nb = nbytes;
      run(TWC_CMD_WITEM, 8'h3C);
      check("refused flag", 8'h01, {7'h0, r.err});
      check("silent link", nb[7:0], nbytes[7:0]);
      for (int c = 0; c < 9; c++) begin
         d = (c < 8) ? c[7:0] : 8'h08 | 8'($urandom);
         run(TWC_CMD_CTRL, d);
         check("control byte", d, ctrl_q);
         check("control address", 8'h62, addr_q);
      end
      run(TWC_CMD_STATUS, 8'h00);
      s1 = r.data;
      check("ready after control", 8'h01, {7'h0, s1[READY_BIT]});
      run(TWC_CMD_STATUS, 8'h00);
      check("status refreshed", 8'h01, {7'h0, r.data[7:5] != s1[7:5]});
      check("status address", 8'h63, addr_q);
      for (int t = 0; t < 6; t++) begin
         slow <= 2'($urandom_range(0, 3));
         run(TWC_CMD_CTRL, 8'($urandom_range(0, 5)));
         for (int j = 0; j < 2; j++) begin
            d = 8'($urandom);
            if (t[0]) begin
               run(TWC_CMD_RITEM, d);
               check("item read", item_val(nread), r.data);
               nread++;
            end else begin
               run(TWC_CMD_WITEM, d);
               check("item write", d, wbyte_q);
            end
         end
      end
      slow <= 2'h3;
      run(TWC_CMD_CTRL, CODE_COEF);
      for (int j = 0; j < 4; j++) begin
         if (j == 2)
            run(TWC_CMD_CTRL, 8'h07);
         d = 8'($urandom);
         nb = nbytes;
         run(TWC_CMD_WITEM, d);
         check("coefficient byte", d, wbyte_q);
         if (j < 2)
            check("unpolled bytes", 8'h01, 8'(nbytes - nb));
      end
      run(TWC_CMD_RESET, 8'h00);
      run(TWC_CMD_RITEM, 8'h00);
      check("refused after reset", 8'h01, {7'h0, r.err});
      run(TWC_CMD_STATUS, 8'h00);
      check("ready cleared", 8'h00, {7'h0, r.data[READY_BIT]});
      check("protocol faults", 8'h00, perr[7:0]);
      check("drive clash", 8'h00, clash[7:0]);
      final_report();
   end
   initial begin
      repeat (90000) @(posedge clock);
      fails++;
      $display("FAIL watchdog expected done seen hang");
      final_report();
   end
endmodule

// ==== twc_dev_model.sv ====
// Purpose: Behavioural model of the decoder's three-wire control port
// Assumes: Host makes bit clock and select; one device on the bus
// Notes: Outside coefficient mode, ready comes back only after slow+1 status reads or a new control byte, so polling is real
`timescale 1ns/1ps
module twc_dev_model
   import twc_pkg::*;
(
   input wire logic dev_reset,
   input wire logic ctl_bit_clock,
   input wire logic addr_data_select,
   input wire logic line,
   input wire logic [1:0] slow,
   output logic data_o,
   output logic data_oe,
   output logic [7:0] ctrl_q,
   output logic [7:0] wbyte_q,
   output logic [7:0] addr_q,
   output int nbytes,
   output int perr
);
   logic [7:0] sh_q, tx_q;
   logic [2:0] fresh_q;
   logic [1:0] mode_q;
   logic was0, init_hi, init_ok, addr_ok, talked, mine, rdy, coef, seen;
   int cnt, polls, nitem;

   // ==========
   // Reset and start-up pulse
   initial begin
      nbytes = 0;
      perr = 0;
      nitem = 0;
      fresh_q = 3'h0;
      data_o = 1'b0;
      data_oe = 1'b0;
      was0 = 1'b0;
   end
   always @(posedge dev_reset) begin
      {init_hi, init_ok, addr_ok, talked, mine, rdy, coef, seen, data_oe} = '0;
      cnt = 0;
      polls = 0;
   end
   always @(addr_data_select) begin
      // Select and reset release move on one host edge; look once both have settled
      #1;
      cnt = 0;
      if (dev_reset !== 1'b0) begin
         if (addr_data_select === 1'b1)
            perr++;
      end else if (!init_ok) begin
         if (ctl_bit_clock !== 1'b1)
            perr++;
         init_ok = init_hi && !addr_data_select;
         init_hi = addr_data_select;
      end else if (addr_data_select && addr_ok && mine && mode_q[0]) begin
         tx_q = mode_q[1] ? {fresh_q, 4'h0, rdy} : 8'h5A + nitem[7:0];
         data_oe = 1'b1;
         data_o = tx_q[0];
      end else if (data_oe) begin
         data_oe = 1'b0;
         // Released line must not keep showing the last bit
         data_o = ~data_o;
      end
   end

   // ==========
   // Bit shifting and byte handling
   always @(negedge ctl_bit_clock) begin
      was0 = 1'b1;
      if (data_oe)
         data_o = tx_q[cnt[2:0]];
   end
   always @(posedge ctl_bit_clock) begin
      if (was0) begin
         was0 = 1'b0;
         if (dev_reset !== 1'b0 || !init_ok)
            perr++;
         sh_q = {line, sh_q[7:1]};
         cnt++;
         if (cnt == 8) begin
            cnt = 0;
            if (!addr_data_select) begin
               addr_q = sh_q;
               mine = (sh_q[7:2] == ADDR_TOP);
               mode_q = sh_q[1:0];
               addr_ok = 1'b1;
               if (mine && !talked && !mode_q[1])
                  perr++;
               talked = talked || mine;
            end else if (!addr_ok)
               perr++;
            else if (mine) begin
               nbytes++;
               case (mode_q)
                  MODE_CTRL: begin
                     ctrl_q = sh_q;
                     rdy = 1'b1;
                     seen = 1'b1;
                     coef = (sh_q == CODE_COEF);
                  end
                  MODE_STATUS: begin
                     polls++;
                     if (seen && polls > slow)
                        rdy = 1'b1;
                     fresh_q++;
                     tx_q = {fresh_q, 4'h0, rdy};
                  end
                  default: begin
                     if (!rdy)
                        perr++;
                     if (mode_q == MODE_WITEM)
                        wbyte_q = sh_q;
                     else
                        nitem++;
                     rdy = coef;
                     polls = 0;
                  end
               endcase
            end
         end
      end
   end
endmodule

// ==== twc_host.sv ====
// Purpose: Host controller driving a three-wire serial control port
// Assumes: Bit clock derived here by division; data line input is asynchronous
// Notes: Item commands poll status first unless coefficients are being written
`timescale 1ns/1ps
module twc_host
   import twc_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire twc_cmd_type cmd,
   output logic cmd_ready,
   output logic rsp_valid,
   output twc_rsp_type rsp,
   output logic dev_reset,
   output logic ctl_bit_clock,
   output logic addr_data_select,
   input wire logic ctl_serial_data_i,
   output logic ctl_serial_data_o,
   output logic ctl_serial_data_oe
);

   // ==========================================================
   // Decoding helpers
   function automatic logic is_read(input logic [1:0] m);
      is_read = m[0];
   endfunction

   function automatic logic [1:0] kind_mode(input twc_kind_type k);
      case (k)
         TWC_CMD_CTRL: kind_mode = MODE_CTRL;
         TWC_CMD_STATUS: kind_mode = MODE_STATUS;
         TWC_CMD_WITEM: kind_mode = MODE_WITEM;
         default: kind_mode = MODE_RITEM;
      endcase
   endfunction

   function automatic logic is_item(input twc_kind_type k);
      is_item = (k == TWC_CMD_WITEM) || (k == TWC_CMD_RITEM);
   endfunction

   // ==========================================================
   // Declarations
   twc_state_type state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [2:0] bit_q, bit_d;
   logic [7:0] shift_q, byte_q;
   logic [1:0] mode_q, item_mode_q, first_mode;
   logic poll_q, ctrl_done_q, nopoll_q, clk_q, sel_q, oe_q, rdy_q, dev_rst_q;
   logic din_m_q, din_s_q;
   logic rsp_valid_q;
   twc_rsp_type rsp_q;
   logic take, refuse, tick, shifting, bit_end, byte_end, poll_again, go_poll;

   assign take = cmd_valid && rdy_q;
   // Item bytes before any control byte would confuse the port
   assign refuse = take && is_item(cmd.kind) && !ctrl_done_q;
   assign go_poll = is_item(cmd.kind) && !nopoll_q;
   assign first_mode = go_poll ? MODE_STATUS : kind_mode(cmd.kind);
   assign tick = (cnt_q == '0);
   assign shifting = (state_q == S_ADDR) || (state_q == S_DATA);
   assign bit_end = shifting && clk_q && tick;
   assign byte_end = bit_end && (bit_q == 3'h7);
   assign poll_again = poll_q && !shift_q[READY_BIT];

   // ==========================================================
   // Pin input synchroniser
   always_ff @(posedge clock) begin
      if (rst) begin
         din_m_q <= 1'b0;
         din_s_q <= 1'b0;
      end else begin
         din_m_q <= ctl_serial_data_i;
         din_s_q <= din_m_q;
      end
   end

   // ==========================================================
   // Sequencer
   always_comb begin
      state_d = state_q;
      cnt_d = tick ? cnt_q : cnt_q - 1'b1;
      bit_d = bit_q;
      case (state_q)
         S_IDLE: begin
            if (take && cmd.kind == TWC_CMD_RESET) begin
               state_d = S_RESET;
               cnt_d = CNT_W'(RESET_CYC - 1);
            end else if (take && !refuse) begin
               state_d = S_ADDR;
               cnt_d = CNT_W'(HALF_CYC - 1);
               bit_d = 3'h0;
            end
         end
         S_RESET: begin
            if (tick) begin
               state_d = S_INIT_HI;
               cnt_d = CNT_W'(GAP_CYC - 1);
            end
         end
         S_INIT_HI: begin
            if (tick) begin
               state_d = S_INIT_LO;
               cnt_d = CNT_W'(GAP_CYC - 1);
            end
         end
         S_INIT_LO: begin
            if (tick) begin
               state_d = S_IDLE;
            end
         end
         S_ADDR, S_DATA: begin
            if (tick) begin
               cnt_d = CNT_W'(HALF_CYC - 1);
               if (bit_end) begin
                  bit_d = bit_q + 3'h1;
               end
               if (byte_end) begin
                  state_d = (state_q == S_ADDR) ? S_GAP : S_END;
                  cnt_d = CNT_W'(GAP_CYC - 1);
               end
            end
         end
         S_GAP: begin
            if (tick) begin
               state_d = S_DATA;
               cnt_d = CNT_W'(HALF_CYC - 1);
               bit_d = 3'h0;
            end
         end
         S_END: begin
            if (tick) begin
               cnt_d = CNT_W'(GAP_CYC - 1);
               if (poll_again) begin
                  state_d = S_GAP;
               end else if (poll_q) begin
                  state_d = S_ADDR;
                  cnt_d = CNT_W'(HALF_CYC - 1);
                  bit_d = 3'h0;
               end else begin
                  state_d = S_IDLE;
               end
            end
         end
         default: state_d = S_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= S_RESET;
         cnt_q <= CNT_W'(RESET_CYC - 1);
         bit_q <= 3'h0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         bit_q <= bit_d;
      end
   end

   // ==========================================================
   // Mode and command hold
   always_ff @(posedge clock) begin
      if (rst) begin
         mode_q <= MODE_CTRL;
         item_mode_q <= MODE_WITEM;
         poll_q <= 1'b0;
         byte_q <= 8'h00;
      end else if (state_q == S_IDLE && take && !refuse) begin
         mode_q <= first_mode;
         item_mode_q <= kind_mode(cmd.kind);
         poll_q <= go_poll;
         byte_q <= cmd.data;
      end else if (state_q == S_END && tick && poll_q && !poll_again) begin
         mode_q <= item_mode_q;
         poll_q <= 1'b0;
      end
   end

   // ==========================================================
   // Shift register: presents bit 0, takes the line into bit 7
   always_ff @(posedge clock) begin
      if (rst) begin
         shift_q <= 8'h00;
      end else if (state_q == S_IDLE && take) begin
         shift_q <= {ADDR_TOP, first_mode};
      end else if (state_q == S_END && tick && poll_q && !poll_again) begin
         shift_q <= {ADDR_TOP, item_mode_q};
      end else if (state_q == S_GAP && tick) begin
         shift_q <= byte_q;
      end else if (bit_end) begin
         shift_q <= {din_s_q, shift_q[7:1]};
      end
   end

   // ==========================================================
   // Link pins
   always_ff @(posedge clock) begin
      if (rst) begin
         clk_q <= 1'b1;
      end else if (state_d == S_ADDR || state_d == S_DATA) begin
         if (state_q != state_d) begin
            clk_q <= 1'b0;
         end else if (tick) begin
            clk_q <= !clk_q || byte_end;
         end
      end else begin
         clk_q <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         sel_q <= 1'b0;
         oe_q <= 1'b0;
         dev_rst_q <= 1'b1;
      end else begin
         // Select stays high between repeated status reads, so no new address
         sel_q <= (state_d == S_GAP) || (state_d == S_DATA) || (state_d == S_INIT_HI)
            || (state_d == S_END && poll_q && state_q == S_END && poll_again)
            || (state_d == S_END && state_q == S_DATA && poll_q && !shift_q[1]);
         oe_q <= (state_d == S_ADDR) || (state_d == S_DATA && !is_read(mode_q));
         dev_rst_q <= (state_d == S_RESET);
      end
   end

   // ==========================================================
   // Control tracking and user side
   always_ff @(posedge clock) begin
      if (rst || state_q == S_RESET) begin
         ctrl_done_q <= 1'b0;
         nopoll_q <= 1'b0;
      end else if (state_q == S_DATA && byte_end && mode_q == MODE_CTRL) begin
         ctrl_done_q <= 1'b1;
         // Coefficient writes skip polling; any other code restores it
         nopoll_q <= (byte_q == CODE_COEF);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         rdy_q <= 1'b0;
         rsp_valid_q <= 1'b0;
         rsp_q <= '0;
      end else begin
         rdy_q <= (state_d == S_IDLE);
         rsp_valid_q <= refuse || (state_q == S_END && tick && !poll_q);
         if (refuse) begin
            rsp_q <= '{err: 1'b1, data: 8'h00};
         end else begin
            rsp_q <= '{err: 1'b0, data: is_read(mode_q) ? shift_q : 8'h00};
         end
      end
   end

   assign cmd_ready = rdy_q;
   assign rsp_valid = rsp_valid_q;
   assign rsp = rsp_q;
   assign dev_reset = dev_rst_q;
   assign ctl_bit_clock = clk_q;
   assign addr_data_select = sel_q;
   assign ctl_serial_data_o = shift_q[0];
   assign ctl_serial_data_oe = oe_q;

   // ==========================================================
   // Assertions
   property p_rst_pins;
      @(posedge clock) disable iff (rst) dev_rst_q |-> !sel_q && clk_q && !oe_q;
   endproperty
   a_rst_pins: assert property (p_rst_pins) else $error("pins active in reset");

   property p_no_use_in_reset;
      @(posedge clock) disable iff (rst) dev_rst_q |-> !rdy_q;
   endproperty
   a_no_use_in_reset: assert property (p_no_use_in_reset) else $error("ready in reset");

   property p_init_pulse;
      @(posedge clock) disable iff (rst) $fell(dev_rst_q) |-> sel_q && clk_q;
   endproperty
   a_init_pulse: assert property (p_init_pulse) else $error("no select pulse");

   property p_addr_low;
      @(posedge clock) disable iff (rst) (state_q == S_ADDR) |-> !sel_q && oe_q;
   endproperty
   a_addr_low: assert property (p_addr_low) else $error("address with select high");

   property p_addr_value;
      @(posedge clock) disable iff (rst)
         (state_q == S_ADDR && bit_q == 3'h0) |-> shift_q[7:2] == ADDR_TOP;
   endproperty
   a_addr_value: assert property (p_addr_value) else $error("bad address");

   property p_data_high;
      @(posedge clock) disable iff (rst) (state_q == S_DATA) |-> sel_q;
   endproperty
   a_data_high: assert property (p_data_high) else $error("data with select low");

   property p_read_release;
      @(posedge clock) disable iff (rst) (state_q == S_DATA && is_read(mode_q)) |-> !oe_q;
   endproperty
   a_read_release: assert property (p_read_release) else $error("drove read phase");

   property p_item_after_ctrl;
      @(posedge clock) disable iff (rst)
         (state_q == S_DATA && !mode_q[1]) |-> ctrl_done_q;
   endproperty
   a_item_after_ctrl: assert property (p_item_after_ctrl) else $error("item first");

   property p_ctrl_no_poll;
      @(posedge clock) disable iff (rst) (state_q == S_DATA && mode_q == MODE_CTRL) |-> !poll_q;
   endproperty
   a_ctrl_no_poll: assert property (p_ctrl_no_poll) else $error("polled control");

   property p_poll_ready;
      @(posedge clock) disable iff (rst)
         (state_q == S_END && tick && poll_q && shift_q[READY_BIT]) |=> state_q == S_ADDR;
   endproperty
   a_poll_ready: assert property (p_poll_ready) else $error("ready ignored");

   property p_byte_time;
      @(posedge clock) disable iff (rst)
         $rose(state_q == S_DATA) |-> ##[200:220] (state_q == S_END);
   endproperty
   a_byte_time: assert property (p_byte_time) else $error("byte length wrong");

   c_reset_seq: cover property (@(posedge clock) $fell(dev_rst_q) ##[1:60] rdy_q);
   c_poll_retry: cover property (@(posedge clock) state_q == S_END ##1 state_q == S_GAP);
   c_item_read: cover property (@(posedge clock) rsp_valid_q && !rsp_q.err && mode_q == MODE_RITEM);
endmodule

// ==== twc_pkg.sv ====
// Purpose: Shared constants and types for the three-wire control port host
// Assumes: 125 MHz system clock; host makes the bit clock by division
// Notes: Bits shift least significant first
// Notes on behaviour
// - Host opens each exchange with an 8-bit address while select is low.
// - Data bytes follow with select high; only the addressed device joins in.
// - An item transfer starts with its control byte, then whole bytes.
// - Host checks the ready flag before every item data byte; the host skips the check after control code 06 (coefficients).
// - No port use during device reset; re-initialise after every reset.
// - During reset select stays low, bit clock high, no transfers.
// - After reset release, pulse select high then low with clock high.
// - First transfer after that pulse is an address phase, select low.
// - First transfer to the device after reset is control write or status.
// - Control bytes need no polling; each new one replaces the last.
// - Data line is two-way; device drives it only in read data phases.
// - Write-control address is 01100010; other modes change the low two bits.
package twc_pkg;
   localparam int CLK_MHZ = 125;
   localparam int T_HALF_NS = 100;
   localparam int T_GAP_NS = 200;
   localparam int T_RESET_NS = 1000;
   localparam int HALF_CYC = (T_HALF_NS * CLK_MHZ + 999) / 1000;
   localparam int GAP_CYC = (T_GAP_NS * CLK_MHZ + 999) / 1000;
   localparam int RESET_CYC = (T_RESET_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 8;
   localparam logic [5:0] ADDR_TOP = 6'h18;
   localparam logic [1:0] MODE_WITEM = 2'h0;
   localparam logic [1:0] MODE_RITEM = 2'h1;
   localparam logic [1:0] MODE_CTRL = 2'h2;
   localparam logic [1:0] MODE_STATUS = 2'h3;
   localparam logic [7:0] CODE_COEF = 8'h06;
   localparam int READY_BIT = 0;

   typedef enum logic [2:0] {
      TWC_CMD_CTRL = 3'h0,
      TWC_CMD_STATUS = 3'h1,
      TWC_CMD_WITEM = 3'h2,
      TWC_CMD_RITEM = 3'h3,
      TWC_CMD_RESET = 3'h4
   } twc_kind_type;

   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_ADDR = 3'h1,
      S_GAP = 3'h3,
      S_DATA = 3'h2,
      S_END = 3'h6,
      S_RESET = 3'h7,
      S_INIT_HI = 3'h5,
      S_INIT_LO = 3'h4
   } twc_state_type;

   typedef struct packed {
      twc_kind_type kind;
      logic [7:0] data;
   } twc_cmd_type;

   typedef struct packed {
      logic err;
      logic [7:0] data;
   } twc_rsp_type;
endpackage
